/* File: rtl/tci_top.sv */
// Tuner control: two-wire target port, registers and tuning control
`default_nettype none
module tci_top
  import tci_pkg::*;
#(
  parameter int FULL_SETTLE_CYC = TCI_FULL_CYC // Long retune settle count
)
(
  input wire logic core_clk, // Core clock, 20 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic ref_clk, // Crystal reference clock
  input wire logic scl_i, // Bus clock pin level
  input wire logic sda_i, // Bus data pin level
  input wire logic sleep_pin, // Hardware power-down pin
  input wire logic pfd_in_lock, // Analog phase detector in lock
  input wire logic fll_locked, // Baseband filter loop locked
  input wire logic vtune_high, // Tuning voltage near upper rail
  input wire logic vtune_low, // Tuning voltage near lower rail
  output logic sda_o, // Data pin drive value, always low
  output logic sda_oe_n, // Low while pulling data low
  output logic [14:0] lo_div_word, // Applied LO divide word
  output tci_tune_t tune, // Oscillator, band, division, pump
  output tci_bb_t bb, // Baseband gain and filter control
  output logic tuning_busy, // Automatic retune in progress
  output logic rf_passthrough_output, // RF passthrough enable
  output logic chip_powered_down, // Either power-down mode active
  output logic p0_out, // General purpose switch output
  output logic pll_lock_flag // Qualified PLL lock
);

  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_MACK} tci_st_t;

  logic scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;
  logic slp_s1_reg, slp_s2_reg, fll_s1_reg, fll_s2_reg;
  logic vh_s1_reg, vh_s2_reg, vl_s1_reg, vl_s2_reg;
  logic lk_s1_reg, ack_s1_reg, ack_s2_reg, req_tog_reg;
  logic [3:0] sel_held_reg;
  logic ack_tog, lock_ref;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  tci_st_t st_reg;
  tci_kind_t kind_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg, ptr_reg;
  logic rd_mode_reg, wr_pulse_reg;
  logic [3:0] wr_idx_reg;
  logic [7:0] wr_data_reg;
  logic [7:0] regs_reg [16];
  logic [7:0] rd_byte;
  logic hi_done_reg, lo_done_reg, new_word_reg;
  logic [13:0] settle_reg;
  logic [9:0] hyst_reg;
  logic [1:0] cp_prog;

  // ==========================================================
  // Pin synchronisers; third stage only for edge detection
  always_ff @(posedge core_clk) begin
    scl_s1_reg <= scl_i;
    scl_s2_reg <= scl_s1_reg;
    scl_d_reg <= scl_s2_reg;
    sda_s1_reg <= sda_i;
    sda_s2_reg <= sda_s1_reg;
    sda_d_reg <= sda_s2_reg;
    slp_s1_reg <= sleep_pin;
    slp_s2_reg <= slp_s1_reg;
    fll_s1_reg <= fll_locked;
    fll_s2_reg <= fll_s1_reg;
    vh_s1_reg <= vtune_high;
    vh_s2_reg <= vh_s1_reg;
    vl_s1_reg <= vtune_low;
    vl_s2_reg <= vl_s1_reg;
    ack_s1_reg <= ack_tog;
    ack_s2_reg <= ack_s1_reg;
  end

  // Lock flag crossing; chip reset forces it low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lk_s1_reg <= 1'b0;
      pll_lock_flag <= 1'b0; // see [R22]
    end else begin
      lk_s1_reg <= lock_ref;
      pll_lock_flag <= lk_s1_reg;
    end
  end

  assign scl_rise = scl_s2_reg & ~scl_d_reg;
  assign scl_fall = ~scl_s2_reg & scl_d_reg;
  assign bus_start = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  assign bus_stop = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

  // ==========================================================
  // Read view: status bits replace the stored ones
  always_comb begin
    rd_byte = regs_reg[ptr_reg];
    case (ptr_reg)
      TCI_R_LO_HI: rd_byte[TCI_F_LOCK] = pll_lock_flag;
      TCI_R_PLL: rd_byte[5:4] = tune.cp_current; // see [R15]
      TCI_R_BBG: rd_byte[TCI_F_LOCK] = fll_s2_reg;
      TCI_R_LOS: rd_byte[TCI_F_LOCK] = pll_lock_flag & ~tuning_busy;
      default: rd_byte = regs_reg[ptr_reg];
    endcase
  end

  // ==========================================================
  // Bus target; sleep pin holds the port dead and released
  always_ff @(posedge core_clk) begin
    wr_pulse_reg <= 1'b0;
    if (rst || slp_s2_reg || bus_stop) begin
      st_reg <= S_IDLE; // see [R21]
      sda_oe_n <= 1'b1;
      bit_cnt_reg <= 4'h0;
      kind_reg <= TCI_K_ADDR;
      rd_mode_reg <= 1'b0;
      shift_reg <= 8'h00;
      if (rst) begin
        ptr_reg <= 4'h0;
        wr_idx_reg <= 4'h0;
        wr_data_reg <= 8'h00;
      end
    end else if (bus_start) begin
      st_reg <= S_RX; // Repeated start keeps the pointer, see [R8]
      kind_reg <= TCI_K_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe_n <= 1'b1;
    end else begin
      case (st_reg)
        S_RX: begin
          if (scl_rise && bit_cnt_reg != 4'h8) begin
            shift_reg <= {shift_reg[6:0], sda_s2_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            bit_cnt_reg <= 4'h0;
            if (kind_reg == TCI_K_ADDR) begin
              if (shift_reg[7:1] == TCI_DEV_ADDR) begin // see [R3]
                st_reg <= S_ACK;
                sda_oe_n <= 1'b0;
                rd_mode_reg <= shift_reg[0]; // see [R2]
              end else begin
                st_reg <= S_IDLE;
              end
            end else begin
              st_reg <= S_ACK; // see [R6] [R7]
              sda_oe_n <= 1'b0;
              if (kind_reg == TCI_K_SUB) begin
                ptr_reg <= shift_reg[3:0]; // see [R5] [R23]
              end else begin
                wr_pulse_reg <= 1'b1;
                wr_idx_reg <= ptr_reg;
                wr_data_reg <= shift_reg;
                ptr_reg <= ptr_reg + 4'h1; // Wraps F to 0, see [R23]
              end
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            if (rd_mode_reg) begin
              st_reg <= S_TX;
              shift_reg <= {rd_byte[6:0], 1'b0};
              sda_oe_n <= rd_byte[7];
              ptr_reg <= ptr_reg + 4'h1; // see [R24]
            end else begin
              st_reg <= S_RX;
              sda_oe_n <= 1'b1;
              kind_reg <= (kind_reg == TCI_K_ADDR) ? TCI_K_SUB : TCI_K_DATA;
            end
          end
        end
        S_TX: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_reg == 4'h8) begin
              st_reg <= S_MACK;
              sda_oe_n <= 1'b1;
              bit_cnt_reg <= 4'h0;
            end else begin
              sda_oe_n <= shift_reg[7];
              shift_reg <= {shift_reg[6:0], 1'b0};
            end
          end
        end
        S_MACK: begin
          // Nack ends the read; ack carries on with the next register
          if (scl_rise) begin
            st_reg <= sda_s2_reg ? S_IDLE : S_ACK; // see [R8] [R24]
          end
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Register file; read-only bits ignore writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        regs_reg[i] <= TCI_REG_RST[i]; // see [R18]
      end
    end else if (wr_pulse_reg) begin
      regs_reg[wr_idx_reg] <= (regs_reg[wr_idx_reg] &
        ~TCI_WR_MASK[wr_idx_reg]) |
        (wr_data_reg & TCI_WR_MASK[wr_idx_reg]); // see [R4] [R1]
    end
  end

  // LO word waits until both halves are written, either order
  always_ff @(posedge core_clk) begin
    new_word_reg <= 1'b0;
    if (rst) begin
      hi_done_reg <= 1'b0;
      lo_done_reg <= 1'b0;
      lo_div_word <= 15'h0000;
    end else if ((hi_done_reg || (wr_pulse_reg && wr_idx_reg == TCI_R_LO_HI))
        && (lo_done_reg || (wr_pulse_reg && wr_idx_reg == TCI_R_LO_LO))) begin
      hi_done_reg <= 1'b0; // see [R20]
      lo_done_reg <= 1'b0;
      new_word_reg <= 1'b1;
      lo_div_word <= {(wr_idx_reg == TCI_R_LO_HI) ? wr_data_reg[6:0] :
                      regs_reg[TCI_R_LO_HI][6:0],
                      (wr_idx_reg == TCI_R_LO_LO) ? wr_data_reg :
                      regs_reg[TCI_R_LO_LO]}; // see [R9]
    end else if (wr_pulse_reg) begin
      hi_done_reg <= hi_done_reg | (wr_idx_reg == TCI_R_LO_HI);
      lo_done_reg <= lo_done_reg | (wr_idx_reg == TCI_R_LO_LO);
    end
  end

  // ==========================================================
  // Automatic oscillator selection and retune timing
  assign cp_prog = regs_reg[TCI_R_PLL][5:4];
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tune <= tci_band(15'h0000, 2'h0);
      settle_reg <= 14'h0000;
      tuning_busy <= 1'b0;
    end else if (new_word_reg) begin
      tune <= tci_band(lo_div_word, cp_prog); // see [R12]
      tuning_busy <= 1'b1;
      // Large jumps get the full search, small ones a short step
      if ((lo_div_word > {tune.vco_sel[1:0], tune.sub_band, 10'h000} ?
           lo_div_word - {tune.vco_sel, tune.sub_band, 10'h000} :
           {tune.vco_sel, tune.sub_band, 10'h000} - lo_div_word)
          > TCI_COARSE_STEP) begin
        settle_reg <= 14'(FULL_SETTLE_CYC); // see [R13]
      end else begin
        settle_reg <= 14'(TCI_FINE_CYC); // see [R13]
      end
    end else begin
      if (settle_reg != 14'h0000) begin
        settle_reg <= settle_reg - 14'h0001;
      end
      tuning_busy <= (settle_reg > 14'h0001);
      // Rail held past the hysteresis window: step the sub-band
      if (hyst_reg == 10'(TCI_HYST_CYC)) begin
        if (vh_s2_reg && tune.sub_band != 3'h7) begin
          tune.sub_band <= tune.sub_band + 3'h1; // see [R14]
        end else if (vl_s2_reg && tune.sub_band != 3'h0) begin
          tune.sub_band <= tune.sub_band - 3'h1; // see [R14]
        end
      end
      // Upper sub-bands need one more pump step; top setting saturates
      tune.cp_current <= (tune.sub_band >= TCI_CP_BUMP_SUB &&
                          cp_prog != TCI_CP_MAX) ?
                         cp_prog + 2'h1 : cp_prog; // see [R15]
    end
  end

  // Hysteresis counter: rail indication must persist uninterrupted
  always_ff @(posedge core_clk) begin
    if (rst || tuning_busy || !(vh_s2_reg ^ vl_s2_reg) ||
        hyst_reg == 10'(TCI_HYST_CYC)) begin
      hyst_reg <= 10'h000; // see [R14]
    end else begin
      hyst_reg <= hyst_reg + 10'h001;
    end
  end

  // ==========================================================
  // Baseband, passthrough and power-down outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bb <= '0;
      rf_passthrough_output <= 1'b1; // see [R18]
      chip_powered_down <= 1'b0;
      p0_out <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      bb.gain <= (regs_reg[TCI_R_BBG][6:3] > TCI_GAIN_MAX) ? TCI_GAIN_MAX :
                 regs_reg[TCI_R_BBG][6:3]; // see [R17]
      bb.filter_code <= regs_reg[TCI_R_BBF];
      bb.fll_enable <= ~(regs_reg[TCI_R_BBC][TCI_F_LF] |
                         regs_reg[TCI_R_BBC][TCI_F_SF]); // see [R16]
      // Passthrough ignores both power-down modes
      rf_passthrough_output <= regs_reg[TCI_R_RF][TCI_F_PASS]; // see [R21]
      chip_powered_down <= slp_s2_reg |
                           regs_reg[TCI_R_GEN][TCI_F_PD]; // see [R19]
      p0_out <= regs_reg[TCI_R_GEN][TCI_F_P0];
      sda_o <= 1'b0;
    end
  end

  // Hand the ratio over only when the previous one was taken
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_held_reg <= 4'h0;
      req_tog_reg <= 1'b0;
    end else if (ack_s2_reg == req_tog_reg &&
                 sel_held_reg != regs_reg[TCI_R_PLL][3:0]) begin
      sel_held_reg <= regs_reg[TCI_R_PLL][3:0]; // see [R10]
      req_tog_reg <= ~req_tog_reg;
    end
  end

  tci_ref_domain u_ref (
    .ref_clk(ref_clk),
    .rst(rst),
    .sel_in(sel_held_reg),
    .req_tog(req_tog_reg),
    .pfd_in_lock(pfd_in_lock),
    .ack_tog(ack_tog),
    .lock_ref(lock_ref)
  );

endmodule
`default_nettype wire

/* File: rtl/tci_pkg.sv */
// Package of constants, types and helpers for the tuner control block
//
// Notes on behaviour
// [R1] All programming goes through the standard-mode two-wire target port.
// [R2] Address byte bit 0 low selects write, high selects read.
// [R3] Only the fixed address C0/C1 hex is answered; it is not configurable.
// [R4] Sixteen byte-wide registers, each writable and readable over the bus.
// [R5] In writes, the byte after the address is the register sub-address.
// [R6] Single write: address, sub-address, one data byte, each acknowledged.
// [R7] Further write bytes go to following registers, acknowledged until stop.
// [R8] Single read: sub-address, repeated start, read address, one byte, nack.
// [R9] LO feedback uses a 15-bit MN+A divider around a 16/17 prescaler.
// [R10] Reference divided to comparison rate by one of a fixed ratio set.
// [R11] Controller keeps comparison frequency at or below 2 MHz.
// [R12] Oscillator, sub-band and LO output division chosen automatically.
// [R13] Tuning algorithm chosen by size of the requested LO change.
// [R14] Conditions watched; retune with hysteresis against needless switching.
// [R15] Charge-pump current raised automatically according to sub-band.
// [R16] Baseband filter calibrated by a frequency-locked loop on the crystal.
// [R17] Twelve baseband gain settings spaced 1.5 dB apart.
// [R18] RF passthrough enabled at power-up and works during power-down.
// [R19] Two power-down modes: hardware sleep pin and a register bit.
// [R20] New LO word applied only after both its registers were written.
// [R21] Sleep pin powers down all incl. bus port; passthrough kept if enabled.
// [R22] Lock flag set after 64 consecutive locked comparisons; reset clears.
// [R23] Pointer uses low four sub-address bits and wraps after the last.
// [R24] Reads return successive registers while the controller acknowledges.
`default_nettype none
package tci_pkg;

  // ==========================================================
  // Bus address and register indices
  localparam logic [6:0] TCI_DEV_ADDR = 7'h60;
  localparam logic [3:0] TCI_R_LO_HI = 4'h0;
  localparam logic [3:0] TCI_R_LO_LO = 4'h1;
  localparam logic [3:0] TCI_R_PLL = 4'h2;
  localparam logic [3:0] TCI_R_RF = 4'h4;
  localparam logic [3:0] TCI_R_BBF = 4'h5;
  localparam logic [3:0] TCI_R_BBC = 4'h6;
  localparam logic [3:0] TCI_R_BBG = 4'h7;
  localparam logic [3:0] TCI_R_LOS = 4'h8;
  localparam logic [3:0] TCI_R_GEN = 4'hF;

  // ==========================================================
  // Field positions
  localparam int TCI_F_LOCK = 7;
  localparam int TCI_F_PASS = 1;
  localparam int TCI_F_PD = 7;
  localparam int TCI_F_P0 = 5;
  localparam int TCI_F_LF = 6;
  localparam int TCI_F_SF = 5;

  // ==========================================================
  // Values after reset, write masks and limits
  localparam logic [7:0] TCI_REG_RST [16] = '{
    8'h00, 8'h00, 8'h00, 8'h40, 8'h6E, 8'h3C, 8'h08, 8'h38,
    8'h20, 8'hA2, 8'hF1, 8'h38, 8'hD0, 8'h10, 8'h30, 8'h00};
  localparam logic [7:0] TCI_WR_MASK [16] = '{
    8'h7F, 8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'hFF, 8'hFF, 8'h7F,
    8'h7F, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'h1F, 8'h3F, 8'hF0};
  localparam logic [3:0] TCI_GAIN_MAX = 4'hB;
  localparam logic [1:0] TCI_CP_MAX = 2'h3;
  localparam logic [2:0] TCI_CP_BUMP_SUB = 3'h4;
  localparam logic [14:0] TCI_COARSE_STEP = 15'h0100;

  // ==========================================================
  // Times and cycle counts (core clock 50 ns)
  localparam int TCI_CLK_NS = 50;
  localparam int TCI_FULL_SETTLE_NS = 200000;
  localparam int TCI_FINE_SETTLE_NS = 20000;
  localparam int TCI_HYST_NS = 50000;
  localparam int TCI_FULL_CYC = TCI_FULL_SETTLE_NS / TCI_CLK_NS;
  localparam int TCI_FINE_CYC = TCI_FINE_SETTLE_NS / TCI_CLK_NS;
  localparam int TCI_HYST_CYC = (TCI_HYST_NS + TCI_CLK_NS - 1) / TCI_CLK_NS;
  localparam logic [6:0] TCI_LOCK_CNT = 7'h40;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {TCI_K_ADDR, TCI_K_SUB, TCI_K_DATA} tci_kind_t;
  typedef struct packed {
    logic [1:0] vco_sel;
    logic [2:0] sub_band;
    logic [1:0] lo_out_div;
    logic [1:0] cp_current;
  } tci_tune_t;
  typedef struct packed {
    logic [3:0] gain;
    logic [7:0] filter_code;
    logic fll_enable;
  } tci_bb_t;

  // Oscillator choice from the LO word; top oscillator absorbs overflow
  function automatic tci_tune_t tci_band(input logic [14:0] word,
                                         input logic [1:0] cp);
    tci_band.vco_sel = (word[14:13] == 2'h3) ? 2'h2 : word[14:13];
    tci_band.sub_band = word[12:10];
    tci_band.lo_out_div = tci_band.vco_sel;
    tci_band.cp_current = cp;
  endfunction

  // Reference divide ratio lookup
  function automatic logic [8:0] tci_ref_ratio(input logic [3:0] sel);
    logic [8:0] base;
    base = sel[3] ? 9'h003 : 9'h002;
    case (sel[2:0])
      3'h0: tci_ref_ratio = base;
      3'h1: tci_ref_ratio = sel[3] ? 9'h005 : 9'h004;
      default: tci_ref_ratio = sel[3] ? 9'(9'h005 << (sel[2:0] - 3'h1)) :
                                        9'(9'h002 << sel[2:0]);
    endcase
  endfunction

endpackage
`default_nettype wire

/* File: rtl/tci_ref_domain.sv */
// Reference-clock domain: reference divider and PLL lock qualifier
`default_nettype none
module tci_ref_domain
  import tci_pkg::*;
(
  input wire logic ref_clk, // Crystal reference clock
  input wire logic rst, // Core reset, synchronised here
  input wire logic [3:0] sel_in, // Ratio select, held while in flight
  input wire logic req_tog, // Core toggles when sel_in is new
  input wire logic pfd_in_lock, // Analog phase detector lock level
  output logic ack_tog, // Echo of req_tog once taken
  output logic lock_ref // Lock flag in this domain
);

  logic rst_s1_reg, rst_ref_reg, req_s1_reg, req_s2_reg;
  logic lk_s1_reg, lk_s2_reg;
  logic [3:0] sel_reg;
  logic [8:0] div_cnt_reg;
  logic [6:0] lock_cnt_reg;
  logic cmp_tick;

  // ==========================================================
  // Synchronisers for reset, request toggle and lock level
  always_ff @(posedge ref_clk) begin
    rst_s1_reg <= rst;
    rst_ref_reg <= rst_s1_reg;
    req_s1_reg <= req_tog;
    req_s2_reg <= req_s1_reg;
    lk_s1_reg <= pfd_in_lock;
    lk_s2_reg <= lk_s1_reg;
  end

  // Take the new ratio; sel_in is stable until the echo returns
  always_ff @(posedge ref_clk) begin
    if (rst_ref_reg) begin
      sel_reg <= 4'h0;
      ack_tog <= 1'b0;
    end else if (req_s2_reg != ack_tog) begin
      sel_reg <= sel_in; // see [R10]
      ack_tog <= req_s2_reg;
    end
  end

  // Reference divider; one tick per comparison cycle
  assign cmp_tick = (div_cnt_reg >= tci_ref_ratio(sel_reg) - 9'h001);
  always_ff @(posedge ref_clk) begin
    if (rst_ref_reg || cmp_tick) begin
      div_cnt_reg <= 9'h000; // see [R10]
    end else begin
      div_cnt_reg <= div_cnt_reg + 9'h001;
    end
  end

  // Lock qualify: any unlocked comparison restarts the count
  always_ff @(posedge ref_clk) begin
    if (rst_ref_reg || !lk_s2_reg) begin
      lock_cnt_reg <= 7'h00; // see [R22]
      lock_ref <= 1'b0;
    end else if (cmp_tick && lock_cnt_reg != TCI_LOCK_CNT) begin
      lock_cnt_reg <= lock_cnt_reg + 7'h01;
      lock_ref <= (lock_cnt_reg == TCI_LOCK_CNT - 7'h01); // see [R22]
    end
  end

endmodule
`default_nettype wire

/* File: dv/tci_checker.sv */
// Port-level assertions for the tuner control block
`default_nettype none
module tci_checker
  import tci_pkg::*;
#(
  parameter int FULL_SETTLE_CYC = 20 // Retune settle count
)
(
  input wire logic core_clk, // Core clock
  input wire logic rst, // Sync reset
  input wire logic scl_i, // Bus clock level
  input wire logic sleep_pin, // Hardware power-down
  input wire logic pfd_in_lock, // Phase detector lock
  input wire logic sda_o, // Data drive value
  input wire logic sda_oe_n, // Data drive enable
  input wire tci_bb_t bb, // Baseband control
  input wire logic rf_passthrough_output, // Passthrough enable
  input wire logic chip_powered_down, // Power-down state
  input wire logic pll_lock_flag // Qualified lock
);
  logic [7:0] pfd_cnt_reg;

  // =====
  // Unbroken lock run in core cycles; a floor, as ref ticks are slower
  always_ff @(posedge core_clk) begin
    if (rst || !pfd_in_lock)
      pfd_cnt_reg <= 8'h00;
    else if (pfd_cnt_reg != 8'hFF)
      pfd_cnt_reg <= pfd_cnt_reg + 8'h01;
  end

  // =====
  // Properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_RST_PASS: assert property (
      $fell(rst) |-> rf_passthrough_output)
    else $error("passthrough off after reset");
  AST_RST_LOCK: assert property (
      $fell(rst) |-> !pll_lock_flag)
    else $error("lock flag set after reset");
  AST_SLEEP_PD: assert property (
      $rose(sleep_pin) |-> ##[1:6] chip_powered_down)
    else $error("sleep pin not followed by power-down");
  AST_SLEEP_QUIET: assert property (
      sleep_pin [*8] |-> sda_oe_n)
    else $error("data pulled low while asleep");
  AST_SDA_EDGE: assert property (
      $changed(sda_oe_n) |-> !scl_i)
    else $error("data drive moved while clock high");
  AST_DRIVE_LOW: assert property (
      !sda_oe_n |-> !sda_o)
    else $error("data driven high");
  AST_GAIN_MAX: assert property (
      bb.gain <= TCI_GAIN_MAX)
    else $error("gain beyond last step");
  AST_LOCK_DROP: assert property (
      !pfd_in_lock [*8] |-> !pll_lock_flag)
    else $error("lock flag kept without lock");
  AST_LOCK_QUAL: assert property (
      $rose(pll_lock_flag) |-> pfd_cnt_reg >= 8'h40)
    else $error("lock flag rose too early");
  AST_PASS_SLEEP: assert property (
      sleep_pin |=> $stable(rf_passthrough_output))
    else $error("passthrough changed while asleep");
endmodule

bind tci_top tci_checker #(.FULL_SETTLE_CYC(FULL_SETTLE_CYC)) u_chk (
  .core_clk, .rst, .scl_i, .sleep_pin, .pfd_in_lock, .sda_o, .sda_oe_n,
  .bb, .rf_passthrough_output, .chip_powered_down, .pll_lock_flag);
`default_nettype wire

/* File: dv/tci_host.sv */
// Bus controller model for the target port of the tuner block
`default_nettype none
module tci_host (
  input wire logic clk, // Core clock for pacing
  input wire logic sda, // Resolved data wire
  output logic scl, // Bus clock, still high when idle
  output logic sda_h // Data drive, 0 pulls low
);
  timeunit 1ns;
  timeprecision 100ps;
  // Quarter bit of 2.5 us keeps high and low phases standard-mode
  localparam int Q = 50;

  // =====
  // Idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One bit; data moves only while clock low, sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    sda_h = b;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    s = sda;
    tick(Q);
    scl = 1'b0;
    tick(Q);
  endtask

  // Start or repeated start: data falls with clock high
  task automatic start();
    sda_h = 1'b1;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    sda_h = 1'b0;
    tick(Q);
    scl = 1'b0;
    tick(Q);
  endtask

  // Stop: data rises with clock high
  task automatic stop();
    sda_h = 1'b0;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    sda_h = 1'b1;
    tick(Q);
  endtask

  // Byte out MSB first, then the target's answer bit
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask

  // Byte in; last byte answered with not-acknowledge
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the tuner control block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sleep_pin = 1'b0;
  logic pfd_in_lock = 1'b0;
  logic scl, sda_h, sda_o, sda_oe_n, ack, pass, pd, p0, lock;
  logic [7:0] rd;
  logic [14:0] lo_div_word;
  tci_pkg::tci_bb_t bb;
  tci_pkg::tci_tune_t tune;
  int error_cnt = 0;
  int checked = 0;
  // Open-drain data wire with pull-up
  wire logic sda = sda_h & (sda_oe_n | sda_o);

  // =====
  // Clocks: core 50 ns, reference 32 ns with unrelated phase
  initial forever #25 core_clk = ~core_clk;
  initial begin
    #7;
    forever #16 ref_clk = ~ref_clk;
  end

  tci_top #(.FULL_SETTLE_CYC(20)) u_dut (
    .core_clk, .rst, .ref_clk, .scl_i(scl), .sda_i(sda), .sleep_pin,
    .pfd_in_lock, .fll_locked(1'b0), .vtune_high(1'b0), .vtune_low(1'b0),
    .sda_o, .sda_oe_n, .lo_div_word, .tune, .bb, .tuning_busy(),
    .rf_passthrough_output(pass), .chip_powered_down(pd), .p0_out(p0),
    .pll_lock_flag(lock));
  tci_host u_host (.clk(core_clk), .sda, .scl, .sda_h);

  // =====
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Write a run of bytes from a sub-address, each one acknowledged
  task automatic wr(input logic [7:0] sub, input logic [7:0] d[$]);
    u_host.start();
    u_host.wr_byte(8'hC0, ack);
    check(16'(ack), 16'h0);
    u_host.wr_byte(sub, ack);
    check(16'(ack), 16'h0);
    foreach (d[i]) begin
      u_host.wr_byte(d[i], ack);
      check(16'(ack), 16'h0);
    end
    u_host.stop();
    cyc(4);
  endtask

  // Sub-address, repeated start, then read expected bytes in turn
  task automatic rdn(input logic [7:0] sub, input logic [7:0] e[$]);
    u_host.start();
    u_host.wr_byte(8'hC0, ack);
    u_host.wr_byte(sub, ack);
    u_host.start();
    u_host.wr_byte(8'hC1, ack);
    check(16'(ack), 16'h0);
    foreach (e[i]) begin
      u_host.rd_byte(i == e.size() - 1, rd);
      check(16'(rd), 16'(e[i]));
    end
    u_host.stop();
  endtask

  // =====
  // Scenarios
  task automatic t_reset();
    check(16'(pass), 16'h1);
    check(16'(lock), 16'h0);
    check(16'(bb.gain), 16'h7);
    $display("test reset done");
  endtask

  // Comparison rate kept under 2 MHz by ratio 16; filter loop held off
  task automatic t_seq();
    wr(8'h02, '{8'h03, 8'h40, 8'h6C, 8'h5A, 8'h48, 8'h60});
    check(16'(pass), 16'h0);
    check(16'(bb.filter_code), 16'h5A);
    check(16'(bb.fll_enable), 16'h0);
    check(16'(bb.gain), 16'(tci_pkg::TCI_GAIN_MAX));
    rdn(8'h05, '{8'h5A, 8'h48});
    rdn(8'h0C, '{8'hD0});
    $display("test sequential done");
  endtask

  // Word 1234 lands in sub-band 4, so the pump steps up once
  task automatic t_wrap_lo();
    wr(8'h1E, '{8'h30, 8'h20, 8'h12});
    check(16'(p0), 16'h1);
    check(16'(lo_div_word), 16'h0);
    wr(8'h01, '{8'h34});
    check(16'(lo_div_word), 16'h1234);
    check(16'(tune), 16'h0041);
    rdn(8'h00, '{8'h12, 8'h34});
    u_host.start();
    u_host.wr_byte(8'hC2, ack);
    check(16'(ack), 16'h1);
    u_host.stop();
    $display("test wrap and divider done");
  endtask

  task automatic t_lock();
    int n;
    pfd_in_lock = 1'b1;
    cyc(40);
    check(16'(lock), 16'h0);
    for (n = 0; n < 3000 && lock !== 1'b1; n++)
      cyc(1);
    check(16'(lock), 16'h1);
    if (lock !== 1'b1)
      end_sim();
    pfd_in_lock = 1'b0;
    cyc(10);
    check(16'(lock), 16'h0);
    $display("test lock done");
  endtask

  task automatic t_sleep();
    wr(8'h04, '{8'h6E});
    sleep_pin = 1'b1;
    cyc(8);
    check(16'(pd), 16'h1);
    check(16'(pass), 16'h1);
    u_host.start();
    u_host.wr_byte(8'hC0, ack);
    check(16'(ack), 16'h1);
    u_host.stop();
    sleep_pin = 1'b0;
    cyc(8);
    check(16'(pd), 16'h0);
    wr(8'h0F, '{8'h80});
    check(16'(pd), 16'h1);
    check(16'(pass), 16'h1);
    wr(8'h0F, '{8'h00});
    check(16'(pd), 16'h0);
    $display("test power-down done");
  endtask

  // Main sequence: reset held three edges, then each scenario in turn
  initial begin
    cyc(3);
    rst = 1'b0;
    cyc(4);
    t_reset();
    t_seq();
    t_wrap_lo();
    t_lock();
    t_sleep();
    end_sim();
  end
endmodule
`default_nettype wire
